// ===== verilog/ssp_defines.svh
// Register map, reset values and timing constants of the serial port
`ifndef SSP_DEFINES_SVH
`define SSP_DEFINES_SVH

`define SSP_ADDR_W       8
`define SSP_CTRL_W       16
`define SSP_OFF_CTRL     8'h00
`define SSP_OFF_STAT     8'h04
`define SSP_OFF_DATA     8'h08
`define SSP_OFF_CRC      8'h0c
`define SSP_OFF_IRQ_ST   8'h10
`define SSP_OFF_IRQ_MASK 8'h14
`define SSP_CTRL_RST     16'h0400
`define SSP_PIN_RST      4'h2
`define SSP_RESP_OKAY    2'h0
`define SSP_RESP_SLVERR  2'h2
`define SSP_CLK_MHZ      40
`define SSP_SCK_MAX_MHZ  16
`define SSP_HALF_MIN     ((`SSP_CLK_MHZ + 2 * `SSP_SCK_MAX_MHZ - 1) / (2 * `SSP_SCK_MAX_MHZ))
`define SSP_SYNC_HALF    7

`endif

// ===== verilog/ssp_pkg.sv
// Types shared by the serial port design
package ssp_pkg;

  typedef enum logic [3:0] {
    SSP_IDLE  = 4'b0001,
    SSP_ARM   = 4'b0010,
    SSP_SHIFT = 4'b0100,
    SSP_DONE  = 4'b1000
  } ssp_state_e;

  typedef struct packed {
    logic [7:0] div;
    logic [2:0] spare;
    logic       crc_next;
    logic       justified;
    logic       i2s;
    logic       master;
    logic       port_enable_bit;
  } ssp_ctrl_s;

  typedef struct packed {
    logic crc_mismatch_flag;
    logic port_busy_flag;
    logic tx_empty_flag;
    logic rx_not_empty_flag;
  } ssp_stat_s;

  typedef struct packed {
    logic crc;
    logic tx;
    logic rx;
  } ssp_irq_s;

  typedef struct packed {
    logic sck;
    logic sdi;
    logic ss_n;
    logic ws;
  } ssp_pin_in_s;

endpackage

// ===== verilog/ssp_port.sv
// SPI / I2S serial port with AXI4-Lite registers
`timescale 1ns/1ps
`include "ssp_defines.svh"

module ssp_port #(
  parameter int               FRAME_W  = 16,
  parameter logic [FRAME_W-1:0] CRC_POLY = 16'h1021
) (
  input  logic                       clk,
  input  logic                       rstn,
  input  logic [`SSP_ADDR_W-1:0]     s_axi_awaddr,
  input  logic                       s_axi_awvalid,
  output logic                       s_axi_awready,
  input  logic [31:0]                s_axi_wdata,
  input  logic [3:0]                 s_axi_wstrb,
  input  logic                       s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  logic                       s_axi_bready,
  input  logic [`SSP_ADDR_W-1:0]     s_axi_araddr,
  input  logic                       s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  logic                       s_axi_rready,
  input  ssp_pkg::ssp_pin_in_s       pin_in,
  output logic                       sck_out,
  output logic                       sck_oe,
  output logic                       sdo,
  output logic                       sdo_oe,
  output logic                       ss_out_n,
  output logic                       irq
);
  import ssp_pkg::*;

  localparam int CNT_W = $clog2(FRAME_W) + 1;
  localparam int GEN_W = $clog2(2 * FRAME_W + 1);
  // Fed-back edge needs five cycles to act and one more to reach sdo; a half period spans it
  localparam int HALF  = (`SSP_HALF_MIN > `SSP_SYNC_HALF) ? `SSP_HALF_MIN : `SSP_SYNC_HALF;

  ssp_pin_in_s               s1, s2, s3, pin_f, pin_p;
  ssp_ctrl_s                 ctrl;
  ssp_irq_s                  irq_st, irq_mask;
  ssp_state_e                state;
  logic [FRAME_W-1:0]        tx_buf, rx_data, shift_tx, shift_rx, crc_acc;
  logic                      tx_empty_flag, rx_not_empty_flag, port_busy_flag;
  logic [CNT_W-1:0]          bit_cnt;
  logic [GEN_W-1:0]          gen_cnt;
  logic [7:0]                div_cnt, half_cyc;
  logic                      aw_held, w_held;
  logic [`SSP_ADDR_W-1:0]    aw_addr;
  logic [31:0]               w_data, wm, rd_word;
  logic [3:0]                w_strb;
  logic                      wr_fire, wr_ctrl, wr_data, wr_irq, wr_mask, rd_data_evt;
  logic                      sck_rise, sck_fall, load_now, in_done, crc_bad;

  function automatic logic is_mapped(input logic [`SSP_ADDR_W-1:0] a);
    return a == `SSP_OFF_CTRL || a == `SSP_OFF_STAT || a == `SSP_OFF_DATA ||
           a == `SSP_OFF_CRC || a == `SSP_OFF_IRQ_ST || a == `SSP_OFF_IRQ_MASK;
  endfunction

  function automatic logic [FRAME_W-1:0] crc_step(input logic [FRAME_W-1:0] c,
                                                  input logic [FRAME_W-1:0] d);
    logic [FRAME_W-1:0] r;
    r = c;
    for (int i = FRAME_W - 1; i >= 0; i--) begin
      r = {r[FRAME_W-2:0], 1'b0} ^ ((r[FRAME_W-1] ^ d[i]) ? CRC_POLY : '0);
    end
    return r;
  endfunction

  // Pin synchroniser; a level counts once stages two and three agree
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s1    <= `SSP_PIN_RST;
      s2    <= `SSP_PIN_RST;
      s3    <= `SSP_PIN_RST;
      pin_f <= `SSP_PIN_RST;
      pin_p <= `SSP_PIN_RST;
    end else begin
      s1    <= pin_in;
      s2    <= s1;
      s3    <= s2;
      pin_f <= (pin_f & (s2 ^ s3)) | (s3 & ~(s2 ^ s3));
      pin_p <= pin_f;
    end
  end

  assign sck_rise = pin_f.sck && !pin_p.sck;
  assign sck_fall = !pin_f.sck && pin_p.sck;
  assign in_done  = (state == SSP_DONE);
  assign half_cyc = (ctrl.div < 8'(HALF)) ? 8'(HALF) : ctrl.div;
  assign crc_bad  = in_done && ctrl.crc_next && (shift_rx != crc_acc);

  always_comb begin
    load_now = 1'b0;
    case (state)
      SSP_IDLE:  load_now = ctrl.port_enable_bit && !ctrl.i2s &&
                            (ctrl.master ? !tx_empty_flag : !pin_f.ss_n);
      SSP_ARM:   load_now = ctrl.port_enable_bit && (pin_f.ws == ctrl.justified);
      SSP_DONE:  load_now = ctrl.port_enable_bit && ctrl.i2s;
      default:   load_now = 1'b0;
    endcase
  end

  // Bus writes wait one cycle when the shifter loads, so the data word is never lost
  assign wr_fire     = aw_held && w_held && !s_axi_bvalid && !load_now;
  assign wr_ctrl     = wr_fire && aw_addr == `SSP_OFF_CTRL;
  assign wr_data     = wr_fire && aw_addr == `SSP_OFF_DATA;
  assign wr_irq      = wr_fire && aw_addr == `SSP_OFF_IRQ_ST;
  assign wr_mask     = wr_fire && aw_addr == `SSP_OFF_IRQ_MASK;
  assign rd_data_evt = s_axi_arvalid && s_axi_arready && s_axi_araddr == `SSP_OFF_DATA;
  assign wm          = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};

  // AXI write channel
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `SSP_RESP_OKAY;
      aw_held       <= 1'b0;
      w_held        <= 1'b0;
      aw_addr       <= '0;
      w_data        <= '0;
      w_strb        <= '0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held       <= 1'b1;
        aw_addr       <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held       <= 1'b1;
        w_data       <= s_axi_wdata;
        w_strb       <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= is_mapped(aw_addr) ? `SSP_RESP_OKAY : `SSP_RESP_SLVERR;
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  always_comb begin
    rd_word = '0;
    case (s_axi_araddr)
      `SSP_OFF_CTRL:     rd_word = 32'(ctrl);
      `SSP_OFF_STAT:     rd_word = 32'(ssp_stat_s'{irq_st.crc, port_busy_flag,
                                                   tx_empty_flag, rx_not_empty_flag});
      `SSP_OFF_DATA:     rd_word = 32'(rx_data);
      `SSP_OFF_CRC:      rd_word = 32'(crc_acc);
      `SSP_OFF_IRQ_ST:   rd_word = 32'(irq_st);
      `SSP_OFF_IRQ_MASK: rd_word = 32'(irq_mask);
      default:           rd_word = '0;
    endcase
  end

  // AXI read channel; answer one cycle after the address is taken
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= `SSP_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_word;
      s_axi_rresp   <= is_mapped(s_axi_araddr) ? `SSP_RESP_OKAY : `SSP_RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // Control register; the one-shot CRC request clears after its frame
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ctrl <= `SSP_CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl <= (ctrl & ~wm[`SSP_CTRL_W-1:0]) | (w_data[`SSP_CTRL_W-1:0] & wm[`SSP_CTRL_W-1:0]);
    end else if (in_done && ctrl.crc_next) begin
      ctrl.crc_next <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tx_buf        <= '0;
      tx_empty_flag <= 1'b1;
    end else if (wr_data) begin
      tx_buf        <= w_data[FRAME_W-1:0];
      tx_empty_flag <= 1'b0;
    end else if (load_now) begin
      // empty as soon as the word starts shifting
      tx_empty_flag <= 1'b1;
    end
  end

  // Frame sequencer
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state    <= SSP_IDLE;
      shift_tx <= '0;
      shift_rx <= '0;
      bit_cnt  <= '0;
    end else begin
      if (load_now) begin
        // Underrun sends zeros rather than stalling an I2S stream
        shift_tx <= tx_empty_flag ? '0 : tx_buf;
        bit_cnt  <= '0;
        state    <= SSP_SHIFT;
      end else begin
        case (state)
          SSP_IDLE: begin
            if (ctrl.port_enable_bit && ctrl.i2s) begin
              state <= SSP_ARM;
            end
          end
          SSP_ARM: begin
            if (!ctrl.port_enable_bit) begin
              state <= SSP_IDLE;
            end
          end
          SSP_SHIFT: begin
            if (!ctrl.master && !ctrl.i2s && pin_f.ss_n) begin
              state <= SSP_IDLE;
            end else begin
              if (sck_rise) begin
                shift_rx <= {shift_rx[FRAME_W-2:0], pin_f.sdi};
                bit_cnt  <= bit_cnt + 1'b1;
                if (bit_cnt == CNT_W'(FRAME_W - 1)) begin
                  state <= SSP_DONE;
                end
              end
              if (sck_fall && bit_cnt != '0) begin
                shift_tx <= {shift_tx[FRAME_W-2:0], 1'b0};
              end
            end
          end
          SSP_DONE: state <= SSP_IDLE;
          default:  state <= SSP_IDLE;
        endcase
      end
    end
  end

  // master clock, half period never below the limit
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sck_out <= 1'b0;
      gen_cnt <= '0;
      div_cnt <= '0;
    end else if (state != SSP_SHIFT || !ctrl.master) begin
      sck_out <= 1'b0;
      gen_cnt <= '0;
      div_cnt <= half_cyc - 8'h01;
    end else if (gen_cnt != GEN_W'(2 * FRAME_W)) begin
      if (div_cnt == 8'h00) begin
        sck_out <= ~sck_out;
        gen_cnt <= gen_cnt + 1'b1;
        div_cnt <= half_cyc - 8'h01;
      end else begin
        div_cnt <= div_cnt - 8'h01;
      end
    end
  end

  // copy and CRC check at frame end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rx_data           <= '0;
      rx_not_empty_flag <= 1'b0;
      crc_acc           <= '0;
    end else begin
      // flag rises with the stored word
      rx_not_empty_flag <= (rx_not_empty_flag && !rd_data_evt) || in_done;
      if (in_done) begin
        rx_data <= shift_rx;
        crc_acc <= ctrl.crc_next ? '0 : crc_step(crc_acc, shift_rx);
      end
    end
  end

  // busy follows the sequencer state and, in enabled master mode, a waiting transmit word; never a stale cross-domain flag
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      port_busy_flag <= 1'b0;
      sck_oe         <= 1'b0;
      sdo_oe         <= 1'b0;
      sdo            <= 1'b0;
      ss_out_n       <= 1'b1;
    end else begin
      port_busy_flag <= state == SSP_SHIFT || state == SSP_DONE ||
                        (ctrl.master && ctrl.port_enable_bit && !tx_empty_flag);
      sck_oe         <= ctrl.master && (ctrl.port_enable_bit || port_busy_flag);
      sdo_oe         <= (ctrl.master || ctrl.i2s) ? (ctrl.port_enable_bit || port_busy_flag)
                                                  : !pin_f.ss_n;
      sdo            <= shift_tx[FRAME_W-1];
      ss_out_n       <= !(ctrl.master && (state == SSP_SHIFT || state == SSP_DONE));
    end
  end

  // Sticky events; a new event wins over a write-one clear
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      irq_st   <= '0;
      irq_mask <= '0;
      irq      <= 1'b0;
    end else begin
      irq_st <= (irq_st & ~(wr_irq ? w_data[2:0] & wm[2:0] : 3'h0)) |
                ssp_irq_s'{crc_bad, load_now && !tx_empty_flag, in_done};
      if (wr_mask) begin
        irq_mask <= (irq_mask & ~wm[2:0]) | (w_data[2:0] & wm[2:0]);
      end
      irq <= |(irq_st & irq_mask);
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  property p_ws_start;
    state == SSP_ARM && ctrl.port_enable_bit && pin_f.ws == ctrl.justified |=> state == SSP_SHIFT;
  endproperty
  a_ws_start: assert property (p_ws_start) else $error("I2S slave did not start on ws");
  property p_slave_idle;
    state == SSP_IDLE && !ctrl.master ##1 state == SSP_IDLE |=> !port_busy_flag;
  endproperty
  a_slave_idle: assert property (p_slave_idle) else $error("Busy set while slave idle");
  property p_rx_not_empty_flag;
    $rose(rx_not_empty_flag) |-> $past(in_done) && rx_data == $past(shift_rx);
  endproperty
  a_rx_not_empty_flag: assert property (p_rx_not_empty_flag) else $error("Receive flag rose without stored word");
  property p_txe;
    load_now && !tx_empty_flag |=> tx_empty_flag && shift_tx == $past(tx_buf);
  endproperty
  a_txe: assert property (p_txe) else $error("Transmit-empty not set on load");
  property p_end_seq;
    in_done && !ctrl.port_enable_bit |=> state == SSP_IDLE ##1 !port_busy_flag;
  endproperty
  a_end_seq: assert property (p_end_seq) else $error("Busy stuck after disabled frame");
  property p_last_bit;
    state == SSP_SHIFT && sck_rise && bit_cnt == CNT_W'(FRAME_W - 1) && !load_now &&
      !(!ctrl.master && !ctrl.i2s && pin_f.ss_n)
      |=> in_done && shift_rx[0] == $past(pin_f.sdi);
  endproperty
  a_last_bit: assert property (p_last_bit) else $error("Last bit not captured");
  property p_copy;
    in_done |=> rx_data == $past(shift_rx);
  endproperty
  a_copy: assert property (p_copy) else $error("Received word not copied");
  property p_crc_set;
    in_done && ctrl.crc_next && shift_rx != crc_acc |=> irq_st.crc;
  endproperty
  a_crc_set: assert property (p_crc_set) else $error("CRC mismatch not flagged");
  property p_crc_only;
    $rose(irq_st.crc) |-> $past(crc_bad);
  endproperty
  a_crc_only: assert property (p_crc_only) else $error("CRC flag without mismatch");
  property p_sck_rate;
    $changed(sck_out) |=> $stable(sck_out) [*2];
  endproperty
  a_sck_rate: assert property (p_sck_rate) else $error("Serial clock too fast");
  property p_busy_clear;
    in_done && !load_now && !ctrl.master |=> ##1 !port_busy_flag;
  endproperty
  a_busy_clear: assert property (p_busy_clear) else $error("Slave busy not cleared");

  c_i2s_start: cover property (state == SSP_ARM ##1 state == SSP_SHIFT);
  c_crc_err:   cover property (crc_bad);
  c_i2s_b2b:   cover property (in_done && ctrl.i2s ##1 state == SSP_SHIFT);
  c_master:    cover property (in_done && ctrl.master);
endmodule

// ===== verif/ssp_far_end.sv
// Far-end model: SPI slave for master mode, SPI or I2S master for slave mode
`timescale 1ns/1ps
module ssp_far_end (
  input  wire logic                 clk,
  input  wire logic                 sck_out,
  input  wire logic                 sck_oe,
  input  wire logic                 sdo,
  input  wire logic                 ss_out_n,
  output wire ssp_pkg::ssp_pin_in_s pin
);
  import ssp_pkg::*;
  logic [15:0] tx_word;
  logic [15:0] rx_word;
  logic [15:0] sh;
  logic        m_sck;
  logic        m_ssn;
  logic        m_ws;
  logic        sdi_v;

  initial begin
    tx_word = 16'h0;
    rx_word = 16'h0;
    sh = 16'h0;
    m_sck = 1'b0;
    m_ssn = 1'b1;
    m_ws = 1'b1;
    sdi_v = 1'b0;
  end

  // Pin loops the driven clock back, as the pad does
  assign pin = {(sck_oe ? sck_out : m_sck), sdi_v, m_ssn, m_ws};

  always @(negedge ss_out_n) begin
    sh = tx_word;
    sdi_v = sh[15];
  end

  always @(posedge sck_out) begin
    if (sck_oe) begin
      rx_word = {rx_word[14:0], sdo};
    end
  end

  always @(negedge sck_out) begin
    if (sck_oe) begin
      sh = {sh[14:0], 1'b0};
      sdi_v = sh[15];
    end
  end

  // Released data line shows the inverse, never a stale bit
  always @(posedge ss_out_n) begin
    sdi_v = ~sdi_v;
  end

  // Must be entered just after a rising clock edge
  task automatic drive_frame(input logic [15:0] w, input logic ws);
    logic [15:0] s;
    s = w;
    m_ws <= ws;
    m_ssn <= 1'b0;
    sdi_v <= s[15];
    repeat (8) @(posedge clk);
    repeat (16) begin
      m_sck <= 1'b1;
      repeat (4) @(posedge clk);
      // Late sample leaves room for the slave's pin synchroniser
      rx_word <= {rx_word[14:0], sdo};
      m_sck <= 1'b0;
      s = {s[14:0], 1'b0};
      sdi_v <= s[15];
      repeat (4) @(posedge clk);
    end
    m_ssn <= 1'b1;
    sdi_v <= 1'b1;
    // Let the released select pass the slave's synchroniser before software looks
    repeat (10) @(posedge clk);
  endtask
endmodule

// ===== verif/ssp_port_tb.sv
// Self-checking bench of the serial port over its register bus
`timescale 1ns/1ps
`include "ssp_defines.svh"
module ssp_port_tb;
  import ssp_pkg::*;
  localparam logic [15:0] POLY = 16'h1021;
  logic        clk;
  logic        rstn;
  logic [7:0]  s_axi_awaddr;
  logic        s_axi_awvalid;
  logic        s_axi_awready;
  logic [31:0] s_axi_wdata;
  logic [3:0]  s_axi_wstrb;
  logic        s_axi_wvalid;
  logic        s_axi_wready;
  logic [1:0]  s_axi_bresp;
  logic        s_axi_bvalid;
  logic        s_axi_bready;
  logic [7:0]  s_axi_araddr;
  logic        s_axi_arvalid;
  logic        s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0]  s_axi_rresp;
  logic        s_axi_rvalid;
  logic        s_axi_rready;
  ssp_pin_in_s pin;
  logic        sck_out;
  logic        sck_oe;
  logic        sdo;
  logic        sdo_oe;
  logic        ss_out_n;
  logic        irq;
  int          errors;
  int          tests_run;
  int          half;
  logic        last_sck;
  logic        jb;
  logic [31:0] rd;
  logic [1:0]  rs;

  ssp_port #(.FRAME_W(16), .CRC_POLY(POLY)) u_ssp_port (
    .clk, .rstn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pin_in(pin), .sck_out, .sck_oe,
    .sdo, .sdo_oe, .ss_out_n, .irq);

  ssp_far_end u_ssp_far_end (.clk, .sck_out, .sck_oe, .sdo, .ss_out_n, .pin);

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid && n < 100);
    rs = s_axi_bresp;
    chk(n < 100, 1, "write answer");
    s_axi_bready <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd_reg(input logic [7:0] a);
    int n;
    n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid && n < 100);
    rd = s_axi_rdata;
    rs = s_axi_rresp;
    chk(n < 100, 1, "read answer");
    s_axi_rready <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input string m);
    rd_reg(a);
    chk(rd, exp, m);
  endtask

  task automatic wait_bit(input int b, input logic v);
    int n;
    n = 0;
    do begin
      rd_reg(`SSP_OFF_STAT);
      n++;
    end while (rd[b] !== v && n < 200);
    chk(rd[b], v, "status wait");
  endtask

  function automatic logic [15:0] crc16(input logic [15:0] d);
    logic [15:0] c;
    c = 16'h0;
    for (int i = 15; i >= 0; i--) begin
      c = {c[14:0], 1'b0} ^ ({16{c[15] ^ d[i]}} & POLY);
    end
    return c;
  endfunction

  // Master frame: device sends tx, far end answers with far
  task automatic mxfer(input logic [15:0] tx, input logic [15:0] far);
    u_ssp_far_end.tx_word = far;
    wr(`SSP_OFF_DATA, {16'h0, tx});
    rd_reg(`SSP_OFF_STAT);
    chk(rd[2:0], 3'b110, "mid-frame status");
    wait_bit(0, 1'b1);
    chk(u_ssp_far_end.rx_word, tx, "far end word");
    rchk(`SSP_OFF_DATA, {16'h0, far}, "received word");
  endtask

  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // Counts edges in each level; three cycles is the floor
  always @(posedge clk) begin
    if (sck_oe === 1'b1 && sck_out !== last_sck) begin
      chk(half >= 3, 1, "sck level too short");
      half = 1;
    end else begin
      half++;
    end
    last_sck = sck_out;
  end

  initial begin
    #(2_000_000);
    errors++;
    complete_run;
  end

  initial begin
    {rstn, s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid} = '0;
    {s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hf;
    {errors, tests_run, half, last_sck, jb} = '0;
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    rchk(`SSP_OFF_CTRL, `SSP_CTRL_RST, "ctrl reset");
    rchk(`SSP_OFF_STAT, 32'h2, "status reset");
    rchk(`SSP_OFF_CRC, 32'h0, "crc reset");
    rchk(`SSP_OFF_IRQ_ST, 32'h0, "event reset");
    rchk(`SSP_OFF_IRQ_MASK, 32'h0, "mask reset");
    rd_reg(8'h18);
    chk(rd, 32'h0, "unmapped read data");
    chk({30'h0, rs}, {30'h0, `SSP_RESP_SLVERR}, "unmapped read");
    wr(8'h18, 32'hffff_ffff);
    chk(rs, `SSP_RESP_SLVERR, "unmapped write");
    wr(`SSP_OFF_STAT, 32'hf);
    rchk(`SSP_OFF_STAT, 32'h2, "read-only status");
    $display("test registers done");
    wr(`SSP_OFF_IRQ_MASK, 32'h1);
    wr(`SSP_OFF_CTRL, 32'h0103);
    mxfer(16'h3c5a, 16'ha5c3);
    chk(irq, 1'b1, "irq raised");
    rchk(`SSP_OFF_CRC, {16'h0, crc16(16'ha5c3)}, "running crc");
    rchk(`SSP_OFF_IRQ_ST, 32'h3, "event bits");
    wr(`SSP_OFF_IRQ_MASK, 32'h0);
    chk(irq, 1'b0, "irq masked");
    wr(`SSP_OFF_IRQ_MASK, 32'h1);
    wr(`SSP_OFF_IRQ_ST, 32'h3);
    rchk(`SSP_OFF_IRQ_ST, 32'h0, "events cleared");
    chk(irq, 1'b0, "irq cleared");
    $display("test master frame done");
    wr(`SSP_OFF_CTRL, 32'h0113);
    mxfer(16'h0, crc16(16'ha5c3));
    rd_reg(`SSP_OFF_STAT);
    chk(rd[3], 1'b0, "good crc");
    rchk(`SSP_OFF_CRC, 32'h0, "crc restarts");
    mxfer(16'h0, 16'h1111);
    wr(`SSP_OFF_CTRL, 32'h0113);
    mxfer(16'h0, crc16(16'h1111) ^ 16'h0001);
    rd_reg(`SSP_OFF_STAT);
    chk(rd[3], 1'b1, "bad crc");
    wr(`SSP_OFF_IRQ_ST, 32'h4);
    rd_reg(`SSP_OFF_STAT);
    chk(rd[3], 1'b0, "crc flag cleared");
    $display("test crc done");
    u_ssp_far_end.tx_word = 16'h0f0f;
    wr(`SSP_OFF_DATA, 32'h8001);
    wait_bit(1, 1'b1);
    wr(`SSP_OFF_CTRL, 32'h0102);
    wait_bit(2, 1'b0);
    chk(u_ssp_far_end.rx_word, 16'h8001, "frame finished");
    rchk(`SSP_OFF_DATA, 32'h0f0f, "last word");
    $display("test disable done");
    wr(`SSP_OFF_CTRL, 32'h0401);
    wr(`SSP_OFF_DATA, 32'h1234);
    u_ssp_far_end.drive_frame(16'hbeef, 1'b1);
    rchk(`SSP_OFF_STAT, 32'h3, "slave frame end");
    chk(u_ssp_far_end.rx_word, 16'h1234, "slave sent");
    rchk(`SSP_OFF_DATA, 32'hbeef, "slave received");
    wr(`SSP_OFF_CTRL, 32'h0400);
    $display("test spi slave done");
    for (int j = 0; j < 2; j++) begin
      jb = j[0];
      u_ssp_far_end.m_ws <= ~jb;
      repeat (8) @(posedge clk);
      wr(`SSP_OFF_CTRL, {28'h40, jb, 3'b101});
      u_ssp_far_end.drive_frame(16'h6b29, ~jb);
      rd_reg(`SSP_OFF_STAT);
      chk(rd[0], 1'b0, "no start on idle level");
      u_ssp_far_end.drive_frame(16'h6b29 ^ {15'h0, jb}, jb);
      wait_bit(0, 1'b1);
      rchk(`SSP_OFF_DATA, {16'h0, 16'h6b29 ^ {15'h0, jb}}, "audio word");
      wr(`SSP_OFF_CTRL, 32'h0400);
      u_ssp_far_end.drive_frame(16'h0, ~jb);
      rd_reg(`SSP_OFF_DATA);
    end
    $display("test audio slave done");
    complete_run;
  end
endmodule
